// ==== rtl/mrie_decode.sv ====
`timescale 1ns/1ps
`include "mrie_defs.svh"
module mrie_decode (
    input wire logic [`MRIE_IW_W-1:0] iw,
    output mrie_pkg::mrie_op_t op
);
    import mrie_pkg::*;
    wire is_move = iw[13:8] == `MRIE_OP_MOVE_FILE_HI;
    wire is_store = (iw[13:7] == `MRIE_OP_STORE_HI);
    wire is_lit = iw[13:10] == `MRIE_OP_LIT_HI;
    wire is_iret = iw == `MRIE_OP_IRET;
    wire is_idle = (iw & `MRIE_IDLE_MASK) == `MRIE_OP_IDLE;
    assign op = is_move ? MRIE_OP_MOVE_FILE_OP :
                is_store ? MRIE_OP_STORE :
                is_lit ? MRIE_OP_LIT :
                is_iret ? MRIE_OP_IRET :
                is_idle ? MRIE_OP_IDLE : MRIE_OP_NONE;
endmodule

// ==== rtl/mrie_defs.svh ====
`ifndef MRIE_DEFS_SVH
`define MRIE_DEFS_SVH

// Instruction word layout (14-bit core word)
`define MRIE_IW_W 14
`define MRIE_ADDR_W 7
`define MRIE_DATA_W 8
`define MRIE_PC_W 13
`define MRIE_DEST_BIT 7
`define MRIE_GIE_BIT 7

// Opcode patterns
`define MRIE_OP_MOVE_FILE_HI 6'h08
`define MRIE_OP_STORE_HI 7'h01
`define MRIE_OP_LIT_HI 4'hc
`define MRIE_OP_IRET 14'h0009
`define MRIE_OP_IDLE 14'h0000
`define MRIE_IDLE_MASK 14'h3f9f

// Reset values
`define MRIE_RESET_PC 13'h0000
`define MRIE_RESET_W 8'h00
`define MRIE_RESET_CTRL 8'h00

`endif

// ==== rtl/mrie_exec.sv ====
`timescale 1ns/1ps
`include "mrie_defs.svh"
// Contract
// - Move-file takes FILE_RDATA while FILE_ADDR holds the previous taken instruction's 7-bit address, passes value unchanged.
// - Destination bit 0 sends value to accumulator, 1 writes back to file.
// - Move-file updates zero flag from moved value.
// - Store copies accumulator into addressed file register, flags untouched.
// - Load-literal puts 8-bit immediate into accumulator, flags untouched.
// - Interrupt return pops stack and loads stack top into program counter.
// - Interrupt return sets global enable bit 7 of interrupt control register.
// - Interrupt return takes two cycles, second cycle does nothing.
module mrie_exec (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Instruction
    input wire logic [`MRIE_IW_W-1:0] INSTR,
    input wire logic INSTR_VALID,
    // File register read port
    output logic [`MRIE_ADDR_W-1:0] FILE_ADDR,
    input wire logic [`MRIE_DATA_W-1:0] FILE_RDATA,
    // File register write port
    output logic FILE_WE,
    output logic [`MRIE_DATA_W-1:0] FILE_WDATA,
    // Hardware stack
    input wire logic [`MRIE_PC_W-1:0] STACK_TOP,
    output logic STACK_POP,
    // Architectural state
    output logic [`MRIE_DATA_W-1:0] ACCUM,
    output logic ZERO_FLAG,
    output logic [`MRIE_DATA_W-1:0] IRQ_CONTROL,
    output logic [`MRIE_PC_W-1:0] PC,
    output logic BUSY,
    output logic ILLEGAL
);
    import mrie_pkg::*;

    mrie_op_t op;
    mrie_state_t state_q, state_d;
    logic [`MRIE_DATA_W-1:0] w_q, w_d, ctrl_q, ctrl_d, fwd_q, fwd_d;
    logic [`MRIE_PC_W-1:0] pc_q, pc_d;
    logic z_q, z_d, fwe_q, fwe_d, pop_q, pop_d, ill_q, ill_d;
    logic [`MRIE_ADDR_W-1:0] fa_q;

    mrie_decode u_dec (
        .iw(INSTR),
        .op(op)
    );

    wire run = (state_q == MRIE_ST_RUN) && INSTR_VALID;
    wire [`MRIE_ADDR_W-1:0] op_addr = INSTR[`MRIE_ADDR_W-1:0];
    wire dest_file = INSTR[`MRIE_DEST_BIT];
    wire [`MRIE_DATA_W-1:0] literal = INSTR[`MRIE_DATA_W-1:0];
    wire [`MRIE_PC_W-1:0] pc_inc = pc_q + `MRIE_PC_W'(1);
    wire do_move = run && op == MRIE_OP_MOVE_FILE_OP;
    wire do_store = run && op == MRIE_OP_STORE;
    wire do_lit = run && op == MRIE_OP_LIT;
    wire do_iret = run && op == MRIE_OP_IRET;
    wire do_none = run && op == MRIE_OP_NONE;

    // Read address port is driven from the registered operand fa_q, one taken instruction behind INSTR
    assign FILE_ADDR = fa_q;

    always_comb begin
        state_d = state_q;
        w_d = w_q;
        z_d = z_q;
        ctrl_d = ctrl_q;
        pc_d = pc_q;
        fwe_d = 1'b0;
        fwd_d = fwd_q;
        pop_d = 1'b0;
        ill_d = 1'b0;
        case (state_q)
            MRIE_ST_RUN: begin
                if (run) begin
                    pc_d = pc_inc;
                end
                if (do_move) begin
                    z_d = (FILE_RDATA == `MRIE_DATA_W'(0));
                    if (dest_file) begin
                        fwe_d = 1'b1;
                        fwd_d = FILE_RDATA;
                    end else begin
                        w_d = FILE_RDATA;
                    end
                end
                if (do_store) begin
                    fwe_d = 1'b1;
                    fwd_d = w_q;
                end
                if (do_lit) begin
                    w_d = literal;
                end
                if (do_iret) begin
                    pc_d = STACK_TOP;
                    pop_d = 1'b1;
                    ctrl_d[`MRIE_GIE_BIT] = 1'b1;
                    state_d = MRIE_ST_FLUSH;
                end
                if (do_none) begin
                    ill_d = 1'b1;
                end
            end
            MRIE_ST_FLUSH: begin
                state_d = MRIE_ST_RUN;
            end
            default: begin
                state_d = MRIE_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_q <= MRIE_ST_RUN;
            w_q <= `MRIE_RESET_W;
            z_q <= 1'b0;
            ctrl_q <= `MRIE_RESET_CTRL;
            pc_q <= `MRIE_RESET_PC;
            fwe_q <= 1'b0;
            fwd_q <= `MRIE_RESET_W;
            pop_q <= 1'b0;
            ill_q <= 1'b0;
        end else begin
            state_q <= state_d;
            w_q <= w_d;
            z_q <= z_d;
            ctrl_q <= ctrl_d;
            pc_q <= pc_d;
            fwe_q <= fwe_d;
            fwd_q <= fwd_d;
            pop_q <= pop_d;
            ill_q <= ill_d;
        end
    end

    // Write address captured with the write so it lines up with FILE_WE
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            fa_q <= '0;
        end else if (run) begin
            fa_q <= op_addr;
        end
    end

    assign FILE_WE = fwe_q;
    assign FILE_WDATA = fwd_q;
    assign STACK_POP = pop_q;
    assign ACCUM = w_q;
    assign ZERO_FLAG = z_q;
    assign IRQ_CONTROL = ctrl_q;
    assign PC = pc_q;
    assign BUSY = state_q == MRIE_ST_FLUSH;
    assign ILLEGAL = ill_q;
endmodule

// ==== rtl/mrie_pkg.sv ====
package mrie_pkg;
    `include "mrie_defs.svh"
    typedef enum logic [2:0] {
        MRIE_OP_NONE  = 3'b000,
        MRIE_OP_MOVE_FILE_OP  = 3'b001,
        MRIE_OP_STORE = 3'b010,
        MRIE_OP_LIT   = 3'b011,
        MRIE_OP_IDLE  = 3'b100,
        MRIE_OP_IRET  = 3'b101
    } mrie_op_t;
    typedef enum logic [0:0] {
        MRIE_ST_RUN   = 1'b0,
        MRIE_ST_FLUSH = 1'b1
    } mrie_state_t;
endpackage

// ==== sim/move_and_return_instr_exec_test.sv ====
`timescale 1ns/1ps
module move_and_return_instr_exec_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic vld = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [12:0] stop = 13'h0000;
    logic [6:0] fa;
    logic [7:0] rd, wd, acc, ic;
    logic we, pop, z, busy, ill;
    logic [12:0] pc;
    logic [7:0] mem [128];
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    mrie_exec u_mrie_exec (.CLK(clk), .RST(rst), .INSTR(instr), .INSTR_VALID(vld),
        .FILE_ADDR(fa), .FILE_RDATA(rd), .FILE_WE(we), .FILE_WDATA(wd), .STACK_TOP(stop),
        .STACK_POP(pop), .ACCUM(acc), .ZERO_FLAG(z), .IRQ_CONTROL(ic), .PC(pc),
        .BUSY(busy), .ILLEGAL(ill));
    always #12.5 clk = ~clk;
    // File register model
    assign rd = mem[instr[6:0]];
    always @(posedge clk) begin
        if (we) mem[fa] <= wd;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            conclude();
        end
    end
    task conclude;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [12:0] got, input logic [12:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task ex(input logic [13:0] iw);
        @(posedge clk);
        instr <= iw;
        vld <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
        #1;
    endtask
    task t_move;
        mem[3] = 8'h00;
        mem[127] = 8'ha5;
        ex(14'h0803);
        chk(acc, 13'h000);
        chk(z, 13'h001);
        ex(14'h30ff);
        chk(acc, 13'h0ff);
        chk(z, 13'h001);
        ex(14'h08ff);
        chk({we, wd}, 13'h1a5);
        chk({fa, z}, {5'h00, 7'h7f, 1'b0});
        chk(acc, 13'h0ff);
    endtask
    task t_store;
        ex(14'h0081);
        @(posedge clk);
        #1;
        chk(mem[1], 13'h0ff);
    endtask
    task t_idle;
        logic [12:0] p;
        p = pc;
        ex(14'h0000);
        chk(pc, p + 13'h1);
        chk(acc, 13'h0ff);
        chk({ill, we}, 13'h000);
        p = pc;
        ex(14'h0100);
        chk({ill, we, pop}, 13'h004);
        chk(pc, p + 13'h1);
        chk(acc, 13'h0ff);
    endtask
    task t_iret;
        @(posedge clk);
        stop <= 13'h1abc;
        instr <= 14'h0009;
        vld <= 1'b1;
        @(posedge clk);
        instr <= 14'h0000;
        #1;
        chk({pop, busy, ic[7]}, 13'h007);
        chk(pc, 13'h1abc);
        @(posedge clk);
        vld <= 1'b0;
        #1;
        chk({busy, pc}, 13'h1abc);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_move();
        t_store();
        t_idle();
        t_iret();
        conclude();
    end
endmodule

// ==== sim/mrie_exec_monitor.sv ====
`timescale 1ns/1ps
module mrie_exec_monitor (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Inputs
    input wire logic [13:0] INSTR,
    input wire logic INSTR_VALID,
    input wire logic [7:0] FILE_RDATA,
    input wire logic [12:0] STACK_TOP,
    // Outputs
    input wire logic [6:0] FILE_ADDR,
    input wire logic FILE_WE,
    input wire logic [7:0] FILE_WDATA,
    input wire logic STACK_POP,
    input wire logic [7:0] ACCUM,
    input wire logic ZERO_FLAG,
    input wire logic [7:0] IRQ_CONTROL,
    input wire logic [12:0] PC,
    input wire logic BUSY
);
    wire tk = INSTR_VALID && !BUSY;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence iret_take;
        tk && INSTR == 14'h0009;
    endsequence
    sequence iret_dead;
        BUSY && STACK_POP ##1 !BUSY;
    endsequence
    iret_steps_a: assert property (iret_take |=> iret_dead)
        else $error("return steps");
    iret_pc_a: assert property (iret_take |=> PC == $past(STACK_TOP) && IRQ_CONTROL[7])
        else $error("return pc");
    dead_hold_a: assert property (BUSY |=> PC == $past(PC))
        else $error("dead cycle");
    move_acc_a: assert property (tk && INSTR[13:7] == 7'h10 |=> ACCUM == $past(FILE_RDATA)
        && ZERO_FLAG == ($past(FILE_RDATA) == 8'h00) && !FILE_WE) else $error("move acc");
    move_back_a: assert property (tk && INSTR[13:7] == 7'h11 |=> FILE_WE
        && FILE_WDATA == $past(FILE_RDATA) && FILE_ADDR == $past(INSTR[6:0])
        && ZERO_FLAG == ($past(FILE_RDATA) == 8'h00)) else $error("move f");
    store_acc_a: assert property (tk && INSTR[13:7] == 7'h01 |=> FILE_WE
        && FILE_WDATA == $past(ACCUM) && $stable(ZERO_FLAG)) else $error("store");
    literal_a: assert property (tk && INSTR[13:10] == 4'hc |=> ACCUM == $past(INSTR[7:0])
        && $stable(ZERO_FLAG)) else $error("literal");
    idle_a: assert property (tk && INSTR == 14'h0000 |=> PC == $past(PC) + 13'h1
        && $stable(ACCUM) && !FILE_WE) else $error("idle");
    one_cycle_a: assert property (tk && INSTR != 14'h0009 |=> !BUSY)
        else $error("busy");
endmodule
bind mrie_exec mrie_exec_monitor u_mon (.CLK, .RST, .INSTR, .INSTR_VALID, .FILE_RDATA,
    .STACK_TOP, .FILE_ADDR, .FILE_WE, .FILE_WDATA, .STACK_POP, .ACCUM, .ZERO_FLAG,
    .IRQ_CONTROL, .PC, .BUSY);
